// ---- core/debug_probe_access_regs.sv ----
`timescale 1ns/10ps
`include "dpa_regs.svh"

// Summary of operation
// - address register is 32 bits, selected by the address test instruction
// - address content counts as valid only while a processor access is pending
// - data register is 32 bits, selected by the data test instruction
// - processor store loads data register; shifted value valid only on pending write
// - data register keeps byte lanes exactly as on the internal bus
// - unused write lanes undefined; probe shifts zeros into unused read lanes
// - byte placement follows endianness taken from endian select input at power-up
// - valid byte count comes from the transfer size field of the control register
// - fast-transfer register is one bit, shifted in and out in the same scan
// - zero shifted in with success clears pending and shifts out a one
// - success needs a pending access inside window FF20_0000 to FF20_000F
// - one shifted in never completes; shifts out whether completion would succeed
// - processor stalls on window access with pending set until probe completes
// - download: probe data written on success, previous data shifted out not valid
// - upload: stored value shifted out, valid only when completion succeeds
// - failed check: no data action, pending unchanged, zero shifted out
// - fast-transfer instruction chains data register with the fast-transfer bit
// - reset-occurred flag plays no part in fast-transfer completion
// - pending access ends only by probe clearing pending, or by reset
// - processor write sets pending and direction, and loads the size field
module debug_probe_access_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire dpa_pkg::jtag_in_s jtag_in,
    output logic tdo,
    output logic tdo_oe,
    input wire logic endian_select_input,
    input wire dpa_pkg::cpu_req_s cpu_req,
    input wire logic pend_clear,
    output logic cpu_done,
    output logic [31:0] cpu_rdata,
    output logic host_access_pending,
    output logic access_direction_flag,
    output logic [1:0] xfer_size,
    output logic [3:0] lane_mask,
    output logic big_endian
);
    import dpa_pkg::*;

    state_s s;
    state_s s_nxt;
    logic tck_rise;
    logic tck_fall;
    logic tms_q;
    logic tdi_q;
    logic fast_ok;
    logic is_fast;

    function automatic tap_state_e tap_next(input tap_state_e st, input logic m);
        tap_state_e n;
        n = st;
        case (st)
            TAP_RESET: begin
                n = TAP_IDLE;
                if (m) begin
                    n = TAP_RESET;
                end
            end
            TAP_IDLE: begin
                n = TAP_IDLE;
                if (m) begin
                    n = TAP_SEL_DR;
                end
            end
            TAP_SEL_DR: begin
                n = TAP_CAP_DR;
                if (m) begin
                    n = TAP_SEL_IR;
                end
            end
            TAP_CAP_DR: begin
                n = TAP_SHIFT_DR;
                if (m) begin
                    n = TAP_EXIT1_DR;
                end
            end
            TAP_SHIFT_DR: begin
                n = TAP_SHIFT_DR;
                if (m) begin
                    n = TAP_EXIT1_DR;
                end
            end
            TAP_EXIT1_DR: begin
                n = TAP_PAUSE_DR;
                if (m) begin
                    n = TAP_UPD_DR;
                end
            end
            TAP_PAUSE_DR: begin
                n = TAP_PAUSE_DR;
                if (m) begin
                    n = TAP_EXIT2_DR;
                end
            end
            TAP_EXIT2_DR: begin
                n = TAP_SHIFT_DR;
                if (m) begin
                    n = TAP_UPD_DR;
                end
            end
            TAP_UPD_DR: begin
                n = TAP_IDLE;
                if (m) begin
                    n = TAP_SEL_DR;
                end
            end
            TAP_SEL_IR: begin
                n = TAP_CAP_IR;
                if (m) begin
                    n = TAP_RESET;
                end
            end
            TAP_CAP_IR: begin
                n = TAP_SHIFT_IR;
                if (m) begin
                    n = TAP_EXIT1_IR;
                end
            end
            TAP_SHIFT_IR: begin
                n = TAP_SHIFT_IR;
                if (m) begin
                    n = TAP_EXIT1_IR;
                end
            end
            TAP_EXIT1_IR: begin
                n = TAP_PAUSE_IR;
                if (m) begin
                    n = TAP_UPD_IR;
                end
            end
            TAP_PAUSE_IR: begin
                n = TAP_PAUSE_IR;
                if (m) begin
                    n = TAP_EXIT2_IR;
                end
            end
            TAP_EXIT2_IR: begin
                n = TAP_SHIFT_IR;
                if (m) begin
                    n = TAP_UPD_IR;
                end
            end
            TAP_UPD_IR: begin
                n = TAP_IDLE;
                if (m) begin
                    n = TAP_SEL_DR;
                end
            end
            default: n = TAP_RESET;
        endcase
        return n;
    endfunction

    // valid lanes in little order, mirrored for big endian; data never moves
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a,
                                         input logic big);
        logic [3:0] m;
        m = 4'h0;
        case (sz)
            `DPA_SZ_BYTE: m = 4'(4'h1 << a);
            `DPA_SZ_HALF: m = a[1] ? 4'hC : 4'h3;
            `DPA_SZ_TRI: m = a[0] ? 4'hE : 4'h7;
            default: m = 4'hF;
        endcase
        if (big) begin
            m = {m[0], m[1], m[2], m[3]};
        end
        return m;
    endfunction

    assign tck_rise = s.tck_s[1] & ~s.tck_d;
    assign tck_fall = ~s.tck_s[1] & s.tck_d;
    assign tms_q = s.tms_s[1];
    assign tdi_q = s.tdi_s[1];
    assign is_fast = (s.ir == `DPA_IR_FASTDATA);
    // rocc is deliberately not an input here
    assign fast_ok = s.pend && (s.addr >= `DPA_FAST_LO) && (s.addr <= `DPA_FAST_HI);

    always_comb begin
        s_nxt = s;
        s_nxt.done = 1'b0;
        // two flops on every pin before use
        s_nxt.tck_s = {s.tck_s[0], jtag_in.tck};
        s_nxt.tms_s = {s.tms_s[0], jtag_in.tms};
        s_nxt.tdi_s = {s.tdi_s[0], jtag_in.tdi};
        s_nxt.end_s = {s.end_s[0], endian_select_input};
        s_nxt.tck_d = s.tck_s[1];

        // endianness is caught once after reset and then held
        if (!s.end_taken) begin
            s_nxt.endian = s.end_s[1];
            s_nxt.end_taken = 1'b1;
        end

        // processor side: a new access is only taken while none is pending
        if (cpu_req.valid && !s.pend) begin
            s_nxt.addr = cpu_req.addr;
            s_nxt.size = cpu_req.size;
            s_nxt.dir = cpu_req.write;
            s_nxt.pend = 1'b1;
            if (cpu_req.write) begin
                s_nxt.data = cpu_req.wdata;
            end
        end

        // the control register clearing pending completes the access
        if (pend_clear && s.pend) begin
            s_nxt.pend = 1'b0;
            s_nxt.done = 1'b1;
        end

        if (tck_rise) begin
            s_nxt.tap = tap_next(s.tap, tms_q);
            case (s.tap)
                TAP_RESET: begin
                    s_nxt.ir = `DPA_IR_BYPASS;
                end
                TAP_CAP_IR: begin
                    s_nxt.ir_sh = `DPA_IR_CAPTURE;
                end
                TAP_SHIFT_IR: begin
                    s_nxt.ir_sh = {tdi_q, s.ir_sh[4:1]};
                end
                TAP_UPD_IR: begin
                    s_nxt.ir = s.ir_sh;
                end
                TAP_CAP_DR: begin
                    if (s.ir == `DPA_IR_ADDRESS) begin
                        s_nxt.dr_sh = {1'b0, s.addr};
                    end else if (s.ir == `DPA_IR_DATA) begin
                        s_nxt.dr_sh = {1'b0, s.data};
                    end else if (is_fast) begin
                        // flag goes out first, then the held data
                        s_nxt.dr_sh = {s.data, fast_ok};
                    end else begin
                        s_nxt.dr_sh = 33'h0_0000_0000;
                    end
                end
                TAP_SHIFT_DR: begin
                    if (is_fast) begin
                        s_nxt.dr_sh = {tdi_q, s.dr_sh[32:1]};
                    end else if (s.ir == `DPA_IR_ADDRESS || s.ir == `DPA_IR_DATA) begin
                        s_nxt.dr_sh = {1'b0, tdi_q, s.dr_sh[31:1]};
                    end else begin
                        s_nxt.dr_sh = {32'h0000_0000, tdi_q};
                    end
                end
                TAP_UPD_DR: begin
                    // address is read only; shifted-in address bits are dropped
                    if (s.ir == `DPA_IR_DATA && s.pend && !s.dir) begin
                        s_nxt.data = s.dr_sh[31:0];
                    end else if (is_fast && !s.dr_sh[0] && fast_ok) begin
                        if (!s.dir) begin
                            s_nxt.data = s.dr_sh[32:1];
                        end
                        s_nxt.pend = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                    // a one shifted in, or a failed check, leaves all untouched
                end
                default: begin
                end
            endcase
        end

        // output changes on the falling edge so the probe samples it stable
        if (tck_fall) begin
            if (s.tap == TAP_SHIFT_DR) begin
                s_nxt.tdo = s.dr_sh[0];
                s_nxt.tdo_oe = 1'b1;
            end else if (s.tap == TAP_SHIFT_IR) begin
                s_nxt.tdo = s.ir_sh[0];
                s_nxt.tdo_oe = 1'b1;
            end else begin
                s_nxt.tdo = 1'b0;
                s_nxt.tdo_oe = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
            s.tap <= TAP_RESET;
            s.ir <= `DPA_IR_BYPASS;
            s.addr <= `DPA_ADDR_RST;
            s.data <= `DPA_DATA_RST;
            // synchronisers run through reset so the endian level is settled at release
            s.tck_s <= s_nxt.tck_s;
            s.tms_s <= s_nxt.tms_s;
            s.tdi_s <= s_nxt.tdi_s;
            s.end_s <= s_nxt.end_s;
            s.tck_d <= s_nxt.tck_d;
        end else begin
            s <= s_nxt;
        end
    end

    assign tdo = s.tdo;
    assign tdo_oe = s.tdo_oe;
    assign cpu_done = s.done;
    assign cpu_rdata = s.data;
    assign host_access_pending = s.pend;
    assign access_direction_flag = s.dir;
    assign xfer_size = s.size;
    assign lane_mask = lanes(s.size, s.addr[1:0], s.endian);
    assign big_endian = s.endian;

endmodule

// ---- core/dpa_pkg.sv ----
package dpa_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_e;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtag_in_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cpu_req_s;

    typedef struct packed {
        logic [1:0] tck_s;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        logic [1:0] end_s;
        logic tck_d;
        tap_state_e tap;
        logic [4:0] ir;
        logic [4:0] ir_sh;
        logic [32:0] dr_sh;
        logic tdo;
        logic tdo_oe;
        logic [31:0] addr;
        logic [31:0] data;
        logic pend;
        logic dir;
        logic [1:0] size;
        logic endian;
        logic end_taken;
        logic done;
    } state_s;

endpackage

// ---- core/dpa_regs.svh ----
`ifndef DPA_REGS_SVH
`define DPA_REGS_SVH

`define DPA_IR_LEN 5
`define DPA_IR_CAPTURE 5'h01
`define DPA_IR_BYPASS 5'h1F
`define DPA_IR_ADDRESS 5'h08
`define DPA_IR_DATA 5'h09
`define DPA_IR_FASTDATA 5'h0E

`define DPA_ADDR_W 32
`define DPA_DATA_W 32
`define DPA_ADDR_RST 32'h0000_0000
`define DPA_DATA_RST 32'h0000_0000

`define DPA_FAST_LO 32'hFF20_0000
`define DPA_FAST_HI 32'hFF20_000F

`define DPA_SZ_BYTE 2'h0
`define DPA_SZ_HALF 2'h1
`define DPA_SZ_WORD 2'h2
`define DPA_SZ_TRI 2'h3

`endif

// ---- testbench/debug_probe_access_regs_tb_top.sv ----
`timescale 1ns/10ps
`include "dpa_regs.svh"
module debug_probe_access_regs_tb_top;
    import dpa_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic pend_clear = 1'b0;
    logic endian_select_input, tdo, tdo_oe, cpu_done, host_access_pending;
    logic access_direction_flag, big_endian, e;
    logic [1:0] xfer_size;
    logic [3:0] lane_mask;
    logic [31:0] cpu_rdata;
    jtag_in_s jtag_in;
    cpu_req_s cpu_req = '0;
    int n_fail = 0;
    int n_tests = 0;
    always #5 sys_clk = ~sys_clk;
    debug_probe_access_regs debug_probe_access_regs_inst (.sys_clk, .rst, .jtag_in, .tdo,
        .tdo_oe, .endian_select_input, .cpu_req, .pend_clear, .cpu_done, .cpu_rdata,
        .host_access_pending, .access_direction_flag, .xfer_size, .lane_mask, .big_endian);
    probe_model probe_model_inst (.sys_clk, .tdo, .tdo_oe, .jtag_in);
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic fast_ok(input logic p, input logic [31:0] a);
        return p && a >= `DPA_FAST_LO && a <= `DPA_FAST_HI;
    endfunction
    function automatic logic [3:0] lane_exp(input logic [1:0] a, input logic big);
        return big ? 4'h8 >> a : 4'h1 << a;
    endfunction
    task automatic request(input logic wr, input logic [1:0] sz, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge sys_clk) cpu_req <= '{1'b1, wr, sz, a, d};
        @(posedge sys_clk) cpu_req.valid <= 1'b0;
        #1;
        chk(host_access_pending, 1'b1);
        chk(access_direction_flag, wr);
        chk(xfer_size, sz);
    endtask
    task automatic clear_pend;
        @(posedge sys_clk) pend_clear <= 1'b1;
        @(posedge sys_clk) pend_clear <= 1'b0;
        #1;
        chk({cpu_done, host_access_pending}, 2'h2);
    endtask
    task automatic ir(input logic [4:0] code);
        logic [32:0] o;
        probe_model_inst.scan(1'b1, `DPA_IR_LEN, {28'h0, code}, o);
        chk(o[4:0], `DPA_IR_CAPTURE);
    endtask
    task automatic dr(input logic [31:0] din, output logic [31:0] dout);
        logic [32:0] o;
        int c;
        c = probe_model_inst.oe_ticks;
        probe_model_inst.scan(1'b0, 32, {1'b0, din}, o);
        dout = o[31:0];
        chk(probe_model_inst.oe_ticks - c, 32);
    endtask
    task automatic fast(input logic wr, input logic [31:0] a, input logic fl, input logic pre);
        logic [32:0] o;
        logic [31:0] d, nd;
        logic ok;
        int c;
        d = $urandom;
        nd = ~d;
        ok = fast_ok(pre, a);
        if (pre) request(wr, `DPA_SZ_WORD, a, d);
        c = probe_model_inst.oe_ticks;
        probe_model_inst.scan(1'b0, 33, {nd, fl}, o);
        chk(probe_model_inst.oe_ticks - c, 33);
        chk(o[0], ok);
        if (ok && wr) chk(o[32:1], d);
        chk(host_access_pending, pre && !(ok && !fl));
        if (ok && !fl && !wr) chk(cpu_rdata, nd);
        if (host_access_pending) clear_pend;
    endtask
    initial begin
        logic [31:0] a, d, v, o;
        logic [3:0] m;
        logic [31:0] tbl [4];
        tbl = '{`DPA_FAST_LO, `DPA_FAST_HI, `DPA_FAST_HI + 1, `DPA_FAST_LO - 1};
        void'($urandom(32'h5f5304cf));
        endian_select_input = 1'($urandom);
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        e = endian_select_input;
        chk(big_endian, e);
        endian_select_input <= ~e;
        a = $urandom;
        d = $urandom;
        request(1'b1, `DPA_SZ_WORD, a, d);
        @(posedge sys_clk) cpu_req <= '{1'b1, 1'b0, `DPA_SZ_BYTE, ~a, ~d};
        @(posedge sys_clk) cpu_req.valid <= 1'b0;
        #1;
        chk({access_direction_flag, xfer_size}, {1'b1, `DPA_SZ_WORD});
        ir(`DPA_IR_ADDRESS);
        dr(~a, o);
        chk(o, a);
        ir(`DPA_IR_DATA);
        dr(~d, o);
        chk(o, d);
        dr(32'h0, o);
        chk(o, d);
        clear_pend;
        a = $urandom;
        request(1'b0, `DPA_SZ_BYTE, a, 32'h0);
        m = lane_exp(a[1:0], e);
        chk(lane_mask, m);
        // unused lanes go out as zero
        v = $urandom & {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
        dr(v, o);
        clear_pend;
        chk(cpu_rdata, v);
        ir(`DPA_IR_FASTDATA);
        fast(1'b0, `DPA_FAST_LO, 1'b0, 1'b0);
        for (int k = 0; k < 16; k++) fast(k[0], tbl[k[3:2]], k[1], 1'b1);
        chk(big_endian, e);
        final_report;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        final_report;
    end
endmodule

// ---- testbench/dpa_checker_assertions.sv ----
`timescale 1ns/10ps
module dpa_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire dpa_pkg::cpu_req_s cpu_req,
    input wire logic pend_clear,
    input wire logic cpu_done,
    input wire logic host_access_pending,
    input wire logic access_direction_flag,
    input wire logic [1:0] xfer_size
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        cpu_req.valid && !host_access_pending;
    endsequence
    sequence s_clear;
        pend_clear && host_access_pending;
    endsequence
    a_pend_set: assert property (s_take |=> host_access_pending) else $error("no pend");
    a_dir_load: assert property (s_take |=> access_direction_flag == $past(cpu_req.write))
        else $error("bad dir");
    a_size_load: assert property (s_take |=> xfer_size == $past(cpu_req.size))
        else $error("bad size");
    a_done_pulse: assert property (cpu_done |=> !cpu_done) else $error("long done");
    a_done_cause: assert property (cpu_done |-> $fell(host_access_pending))
        else $error("done without end");
    a_clear_ends: assert property (s_clear |=> !host_access_pending && cpu_done)
        else $error("clear ignored");
    // a busy core must not see its access fields overwritten by a stray request
    a_busy_hold: assert property (host_access_pending && !pend_clear |=>
        $stable(access_direction_flag) && $stable(xfer_size)) else $error("fields moved");
    a_pend_cause: assert property ($rose(host_access_pending) |-> $past(cpu_req.valid))
        else $error("pend from nowhere");
endmodule
bind debug_probe_access_regs dpa_checker dpa_checker_inst (.sys_clk, .rst, .cpu_req,
    .pend_clear, .cpu_done, .host_access_pending, .access_direction_flag, .xfer_size);

// ---- testbench/probe_model.sv ----
`timescale 1ns/10ps
module probe_model (
    input wire logic sys_clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output dpa_pkg::jtag_in_s jtag_in
);
    // ticks that found the output driven, read by the bench
    int oe_ticks = 0;
    initial jtag_in = '0;
    // tdo is sampled a half period after the fall, well past the sync delay
    task automatic tick(input logic ms, input logic di, output logic dout);
        jtag_in.tck <= 1'b0;
        jtag_in.tms <= ms;
        jtag_in.tdi <= di;
        repeat (8) @(posedge sys_clk);
        dout = tdo;
        if (tdo_oe) begin
            oe_ticks++;
        end
        jtag_in.tck <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic scan(input logic ir, input int n, input logic [32:0] din,
        output logic [32:0] dout);
        logic b;
        dout = '0;
        // one idle tick leaves test-logic-reset and is harmless from idle
        tick(1'b0, 1'b0, b);
        tick(1'b1, 1'b0, b);
        if (ir) tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
        tick(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b);
            dout[i] = b;
        end
        tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
        // tck parks low between scans
        jtag_in.tck <= 1'b0;
        // a spare edge so the next scan never drives tck in the same step
        @(posedge sys_clk);
    endtask
endmodule
